// ### ext_irq_defs.vh
// Constants for the external pin interrupt controller.
`ifndef EXT_IRQ_DEFS_VH
`define EXT_IRQ_DEFS_VH

// Register offsets in I/O space and the shift into data space.
`define EXT_IRQ_FLAG_OFFSET 8'h3A
`define EXT_IRQ_CONTROL_OFFSET 8'h3B
`define EXT_IRQ_DATA_SPACE_SHIFT 8'h20

// Register reset value.
`define EXT_IRQ_REG_RESET 8'h00

// Bit positions inside the control and flag registers.
`define EXT_IRQ_LINE1_BIT 7
`define EXT_IRQ_LINE0_BIT 6
`define EXT_IRQ_VSEL_BIT 1

// Sense-control encodings {sense_hi, sense_lo}.
`define EXT_IRQ_SENSE_LEVEL 2'h0
`define EXT_IRQ_SENSE_ANY 2'h1
`define EXT_IRQ_SENSE_FALL 2'h2
`define EXT_IRQ_SENSE_RISE 2'h3

// Vector table bases (word addresses) and per-line vector indices.
`define EXT_IRQ_APP_BASE 12'h000
`define EXT_IRQ_BOOT_BASE 12'hC00
`define EXT_IRQ_LINE0_INDEX 12'h001
`define EXT_IRQ_LINE1_INDEX 12'h002

// Width of the vector address bus.
`define EXT_IRQ_VEC_W 12

`endif

// ### ext_irq_sense.v
// Pin event detector for one external interrupt line.
`timescale 1ns/1ps
`include "ext_irq_defs.vh"

module ext_irq_sense (
	// Clock, reset and enable
	input wire core_clk_in,
	input wire reset_n_in,
	input wire ce_in,
	// Pin and sense mode
	input wire pin_in,
	input wire [1:0] sense_in,
	// Detector results
	output reg event_out,
	output wire level_mode_out,
	output wire level_active_out
);

	reg pin_prev;
	wire rise;
	wire fall;

	always @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			pin_prev <= 1'b1;
		end else if (ce_in) begin
			pin_prev <= pin_in;
		end
	end

	assign rise = pin_in & ~pin_prev;
	assign fall = ~pin_in & pin_prev;
	assign level_mode_out = (sense_in == `EXT_IRQ_SENSE_LEVEL);
	// Level sensing is active while the pin is held low.
	assign level_active_out = level_mode_out & ~pin_in;

	always @* begin
		case (sense_in)
			`EXT_IRQ_SENSE_ANY: begin
				event_out = rise | fall;
			end
			`EXT_IRQ_SENSE_FALL: begin
				event_out = fall;
			end
			`EXT_IRQ_SENSE_RISE: begin
				event_out = rise;
			end
			default: begin
				event_out = 1'b0;
			end
		endcase
	end

endmodule

// ### ext_irq_ctrl.v
// External pin interrupt controller for two request lines.
`timescale 1ns/1ps
`include "ext_irq_defs.vh"

module ext_irq_ctrl (
	// Clock, reset and enable
	input wire core_clk_in,
	input wire reset_n_in,
	input wire ce_in,
	// Register access from the core
	input wire [7:0] io_addr_in,
	input wire io_data_space_in,
	input wire io_wr_in,
	input wire io_rd_in,
	input wire [7:0] io_wdata_in,
	output reg [7:0] io_rdata_out,
	// Core status and control bits
	input wire global_irq_enable_in,
	input wire line1_sense_hi_in,
	input wire line1_sense_lo_in,
	input wire line0_sense_hi_in,
	input wire line0_sense_lo_in,
	// Pin levels as seen at the pads
	input wire ext_irq0_pin_in,
	input wire ext_irq1_pin_in,
	// Service acknowledge from the core
	input wire irq_ack_in,
	input wire irq_ack_line_in,
	// Request towards the core
	output reg irq_req_out,
	output reg irq_line_out,
	output reg [`EXT_IRQ_VEC_W-1:0] irq_vector_out,
	// Vector select bit and qualified line requests for the rest of the chip
	output reg vector_table_select_out,
	output reg [1:0] pending_out
);

	reg ext_irq1_enable;
	reg ext_irq0_enable;
	reg vector_table_select;
	reg ext_irq1_flag;
	reg ext_irq0_flag;
	reg next_ext_irq1_flag;
	reg next_ext_irq0_flag;
	reg [7:0] next_rdata;

	wire event0;
	wire event1;
	wire level_mode0;
	wire level_mode1;
	wire level_active0;
	wire level_active1;
	wire sel_control;
	wire sel_flag;
	wire wr_control;
	wire wr_flag;
	wire clr_by_sw0;
	wire clr_by_sw1;
	wire clr_by_ack0;
	wire clr_by_ack1;
	wire req0;
	wire req1;
	wire next_req;
	wire next_line;
	wire [`EXT_IRQ_VEC_W-1:0] next_vector;
	wire [1:0] next_pending;
	wire [1:0] sense0;
	wire [1:0] sense1;

	// Matches an access against a register offset in either address space.
	function reg_hit;
		input [7:0] addr;
		input data_space;
		input [7:0] offset;
		begin
			if (data_space) begin
				reg_hit = (addr == offset + `EXT_IRQ_DATA_SPACE_SHIFT);
			end else begin
				reg_hit = (addr == offset);
			end
		end
	endfunction

	// Builds a register byte from the two line bits and the select bit.
	function [7:0] pack_reg;
		input line1_bit;
		input line0_bit;
		input vsel_bit;
		reg [7:0] value;
		begin
			value = `EXT_IRQ_REG_RESET;
			value[`EXT_IRQ_LINE1_BIT] = line1_bit;
			value[`EXT_IRQ_LINE0_BIT] = line0_bit;
			value[`EXT_IRQ_VSEL_BIT] = vsel_bit;
			pack_reg = value;
		end
	endfunction

	// Computes a flag's next value; a new event wins over any clear.
	// Level mode forces zero so no stale edge is left once edge sensing returns.
	function next_flag;
		input flag;
		input level_mode;
		input set_event;
		input clr_sw;
		input clr_ack;
		begin
			if (level_mode) begin
				next_flag = 1'b0;
			end else if (set_event) begin
				next_flag = 1'b1;
			end else if (clr_sw | clr_ack) begin
				next_flag = 1'b0;
			end else begin
				next_flag = flag;
			end
		end
	endfunction

	// Vector address from table placement and line index.
	function [`EXT_IRQ_VEC_W-1:0] vector_of;
		input boot_space;
		input [`EXT_IRQ_VEC_W-1:0] index;
		begin
			if (boot_space) begin
				vector_of = `EXT_IRQ_BOOT_BASE + index;
			end else begin
				vector_of = `EXT_IRQ_APP_BASE + index;
			end
		end
	endfunction

	// Qualified request of one line; in level mode it follows the pin, not the flag.
	function line_request;
		input global_enable;
		input line_enable;
		input level_mode;
		input level_active;
		input flag;
		begin
			if (level_mode) begin
				line_request = global_enable & line_enable & level_active;
			end else begin
				line_request = global_enable & line_enable & flag;
			end
		end
	endfunction

	// Decodes an acknowledge from the core for one line.
	function ack_for;
		input ack;
		input ack_line;
		input line;
		begin
			ack_for = ack & (ack_line == line);
		end
	endfunction

	assign sense0 = {line0_sense_hi_in, line0_sense_lo_in};
	assign sense1 = {line1_sense_hi_in, line1_sense_lo_in};

	ext_irq_sense u_sense0 (
		.core_clk_in(core_clk_in),
		.reset_n_in(reset_n_in),
		.ce_in(ce_in),
		.pin_in(ext_irq0_pin_in),
		.sense_in(sense0),
		.event_out(event0),
		.level_mode_out(level_mode0),
		.level_active_out(level_active0)
	);

	ext_irq_sense u_sense1 (
		.core_clk_in(core_clk_in),
		.reset_n_in(reset_n_in),
		.ce_in(ce_in),
		.pin_in(ext_irq1_pin_in),
		.sense_in(sense1),
		.event_out(event1),
		.level_mode_out(level_mode1),
		.level_active_out(level_active1)
	);

	// Both aliases of a register decode to the same storage.
	// dual address decode
	assign sel_control = reg_hit(io_addr_in, io_data_space_in, `EXT_IRQ_CONTROL_OFFSET);
	assign sel_flag = reg_hit(io_addr_in, io_data_space_in, `EXT_IRQ_FLAG_OFFSET);
	assign wr_control = io_wr_in & sel_control;
	assign wr_flag = io_wr_in & sel_flag;

	assign clr_by_sw0 = wr_flag & io_wdata_in[`EXT_IRQ_LINE0_BIT];
	assign clr_by_sw1 = wr_flag & io_wdata_in[`EXT_IRQ_LINE1_BIT];

	assign clr_by_ack0 = ack_for(irq_ack_in, irq_ack_line_in, 1'b0);
	assign clr_by_ack1 = ack_for(irq_ack_in, irq_ack_line_in, 1'b1);

	always @* begin
		next_ext_irq0_flag = next_flag(ext_irq0_flag, level_mode0, event0,
			clr_by_sw0, clr_by_ack0);
		next_ext_irq1_flag = next_flag(ext_irq1_flag, level_mode1, event1,
			clr_by_sw1, clr_by_ack1);
	end

	// Control register: enables and vector placement.
	// Bits other than these three are not stored and read back as zero.
	always @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			ext_irq1_enable <= 1'b0;
			ext_irq0_enable <= 1'b0;
			vector_table_select <= 1'b0;
		end else if (ce_in && wr_control) begin
			ext_irq1_enable <= io_wdata_in[`EXT_IRQ_LINE1_BIT];
			ext_irq0_enable <= io_wdata_in[`EXT_IRQ_LINE0_BIT];
			vector_table_select <= io_wdata_in[`EXT_IRQ_VSEL_BIT];
		end
	end

	// Flag register.
	// Flags move only on enabled cycles, so a clear while the enable is low is lost.
	always @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			ext_irq1_flag <= 1'b0;
			ext_irq0_flag <= 1'b0;
		end else if (ce_in) begin
			ext_irq1_flag <= next_ext_irq1_flag;
			ext_irq0_flag <= next_ext_irq0_flag;
		end
	end

	assign req0 = line_request(global_irq_enable_in, ext_irq0_enable, level_mode0,
		level_active0, ext_irq0_flag);
	assign req1 = line_request(global_irq_enable_in, ext_irq1_enable, level_mode1,
		level_active1, ext_irq1_flag);

	// Line 0 sits at the lower vector and wins when both request.
	assign next_req = req0 | req1;
	assign next_line = ~req0 & req1;
	assign next_pending = {req1, req0};

	assign next_vector = next_line ?
		vector_of(vector_table_select, `EXT_IRQ_LINE1_INDEX) :
		vector_of(vector_table_select, `EXT_IRQ_LINE0_INDEX);

	// Read data mux; unmapped addresses read as zero.
	always @* begin
		if (sel_control) begin
			next_rdata = pack_reg(ext_irq1_enable, ext_irq0_enable, vector_table_select);
		end else if (sel_flag) begin
			next_rdata = pack_reg(ext_irq1_flag, ext_irq0_flag, 1'b0);
		end else begin
			next_rdata = `EXT_IRQ_REG_RESET;
		end
	end

	// Read data is held until the next read strobe, and frozen with the enable.
	always @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			io_rdata_out <= `EXT_IRQ_REG_RESET;
		end else if (ce_in && io_rd_in) begin
			io_rdata_out <= next_rdata;
		end
	end

	// Request outputs toward the core, registered.
	// The request lags the flag by a cycle, so it stays high for one cycle after
	// an acknowledge; the core must not take the same line again at once.
	always @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			irq_req_out <= 1'b0;
			irq_line_out <= 1'b0;
			irq_vector_out <= `EXT_IRQ_APP_BASE;
			vector_table_select_out <= 1'b0;
			pending_out <= 2'h0;
		end else if (ce_in) begin
			irq_req_out <= next_req;
			irq_line_out <= next_line;
			irq_vector_out <= next_vector;
			vector_table_select_out <= vector_table_select;
			pending_out <= next_pending;
		end
	end

endmodule

// ### ext_irq_ctrl_chk.sv
// Port assertions for the external pin interrupt controller.
`timescale 1ns/1ps
`include "ext_irq_defs.vh"
module ext_irq_ctrl_chk (
	// Clock, reset and register bus
	input logic core_clk_in, reset_n_in, ce_in, io_data_space_in, io_wr_in, io_rd_in,
	input logic [7:0] io_addr_in, io_wdata_in, io_rdata_out,
	// Core side
	input logic global_irq_enable_in, irq_req_out, irq_line_out, vector_table_select_out,
	input logic [11:0] irq_vector_out,
	input logic [1:0] pending_out
);
	wire hit_c = io_addr_in == (io_data_space_in ? 8'h5B : 8'h3B);
	wire hit_f = io_addr_in == (io_data_space_in ? 8'h5A : 8'h3A);
	wire rd = ce_in && io_rd_in;
	wire [11:0] base = vector_table_select_out ? `EXT_IRQ_BOOT_BASE : `EXT_IRQ_APP_BASE;
	wire [11:0] idx = irq_line_out ? `EXT_IRQ_LINE1_INDEX : `EXT_IRQ_LINE0_INDEX;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!reset_n_in);
	property p_reset; disable iff (1'b0) !reset_n_in |=>
		!irq_req_out && pending_out == 2'b00; endproperty
	a_reset: assert property (p_reset) else $error("reset left a request");
	property p_unmapped; rd && !hit_c && !hit_f |=> io_rdata_out == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_ctrl_bits; rd && hit_c |=> io_rdata_out[5:2] == 4'h0 && !io_rdata_out[0]; endproperty
	a_ctrl_bits: assert property (p_ctrl_bits) else $error("control spare bits set");
	property p_flag_bits; rd && hit_f |=> io_rdata_out[5:0] == 6'h00; endproperty
	a_flag_bits: assert property (p_flag_bits) else $error("flag spare bits set");
	property p_vsel; ce_in && io_wr_in && hit_c |->
		##2 vector_table_select_out == $past(io_wdata_in[1], 2); endproperty
	a_vsel: assert property (p_vsel) else $error("vector select not written");
	property p_gie; !global_irq_enable_in [*3] |-> !irq_req_out && pending_out == 2'b00; endproperty
	a_gie: assert property (p_gie) else $error("request without global enable");
	property p_vector; irq_req_out |-> irq_vector_out == base + idx; endproperty
	a_vector: assert property (p_vector) else $error("wrong vector");
	property p_req; pending_out != 2'b00 [*2] |-> irq_req_out; endproperty
	a_req: assert property (p_req) else $error("pending but no request");
	property p_prio; pending_out == 2'b11 [*2] |-> !irq_line_out; endproperty
	a_prio: assert property (p_prio) else $error("line 0 not preferred");
	c_line1: cover property (irq_req_out && irq_line_out);
	c_boot: cover property (irq_req_out && vector_table_select_out);
	c_both: cover property (pending_out == 2'b11);
endmodule

// ### core_model.sv
// Behavioural core that takes each interrupt request and acknowledges it.
`timescale 1ns/1ps
module core_model (
	// Clock and request
	input logic clk_in, req_in, line_in,
	input logic [11:0] vec_in,
	// Acknowledge
	output logic ack_out = 0,
	output logic ack_line_out = 0,
	output int n_ack = 0
);
	logic [11:0] vec_log [0:7];
	int busy = 0;
	always @(posedge clk_in) begin
		#1;
		if (busy == 0 && req_in) begin
			ack_out = 1;
			ack_line_out = line_in;
			vec_log[n_ack % 8] = vec_in;
			n_ack = n_ack + 1;
			busy = 4;
		end else begin
			// The line select means nothing without an acknowledge, so keep it moving.
			ack_out = 0;
			ack_line_out = ~ack_line_out;
			if (busy > 0) busy = busy - 1;
		end
	end
endmodule

// ### tb.sv
// Self-checking bench for the external pin interrupt controller.
`timescale 1ns/1ps
module tb;
	logic clk = 0, rst_n = 0, ds = 0, wr = 0, rd = 0, gie = 0, p0 = 1, p1 = 1, ce = 1;
	logic [1:0] s0 = 0, s1 = 0;
	logic [7:0] addr = 0, wd = 0, e;
	wire [7:0] rdata;
	wire req, line, vsel, ack, ackl;
	wire [11:0] vec;
	wire [1:0] pend;
	int err_count = 0, n_checks = 0, n_ack, i, a0;
	always #10 clk = ~clk;
	ext_irq_ctrl ext_irq_ctrl_inst (.core_clk_in(clk), .reset_n_in(rst_n), .ce_in(ce),
		.io_addr_in(addr), .io_data_space_in(ds), .io_wr_in(wr), .io_rd_in(rd),
		.io_wdata_in(wd), .io_rdata_out(rdata), .global_irq_enable_in(gie),
		.line1_sense_hi_in(s1[1]), .line1_sense_lo_in(s1[0]), .line0_sense_hi_in(s0[1]),
		.line0_sense_lo_in(s0[0]), .ext_irq0_pin_in(p0), .ext_irq1_pin_in(p1),
		.irq_ack_in(ack), .irq_ack_line_in(ackl), .irq_req_out(req), .irq_line_out(line),
		.irq_vector_out(vec), .vector_table_select_out(vsel), .pending_out(pend));
	core_model core_model_inst (.clk_in(clk), .req_in(req), .line_in(line), .vec_in(vec),
		.ack_out(ack), .ack_line_out(ackl), .n_ack(n_ack));
	task automatic chk(input logic [11:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a, d, input logic s);
		@(posedge clk);
		#1;
		{wr, rd, addr, wd, ds} = {w, !w, a, d, s};
		@(posedge clk);
		#1;
		{wr, rd} = 2'b00;
	endtask
	task automatic rdc(input logic [7:0] a, ex);
		acc(0, a, 8'h00, 0);
		chk(rdata, ex);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		wt(10);
		rst_n = 1;
		rdc(8'h3B, 8'h00);
		rdc(8'h3A, 8'h00);
		rdc(8'h3C, 8'h00);
		acc(1, 8'h3B, 8'hFF, 0);
		acc(0, 8'h5B, 8'h00, 1);
		chk(rdata, 8'hC2);
		chk(vsel, 1);
		for (i = 1; i < 4; i++) begin
			{s0, s1} = {i[1:0], i[1:0]};
			acc(1, 8'h3A, 8'hC0, 0);
			{p0, p1} = 2'b00;
			e = (i != 3) ? 8'hC0 : 8'h00;
			acc(1, 8'h3A, 8'h00, 0);
			rdc(8'h3A, e);
			acc(1, 8'h5A, 8'h40, 1);
			rdc(8'h3A, e & 8'h80);
			acc(1, 8'h3A, 8'hC0, 0);
			{p0, p1} = 2'b11;
			wt(2);
			rdc(8'h3A, (i != 2) ? 8'hC0 : 8'h00);
		end
		{s0, s1} = 4'h0;
		acc(1, 8'h3B, 8'hC2, 0);
		{gie, p0, a0} = {2'b10, n_ack};
		wt(20);
		chk(n_ack - a0 >= 2, 1);
		chk(core_model_inst.vec_log[a0 % 8], 12'hC01);
		rdc(8'h3A, 8'h00);
		p0 = 1;
		wt(8);
		{s0, s1, a0} = {4'hA, n_ack};
		{p0, p1} = 2'b00;
		wt(20);
		chk(n_ack - a0, 2);
		chk(core_model_inst.vec_log[a0 % 8], 12'hC01);
		chk(core_model_inst.vec_log[(a0 + 1) % 8], 12'hC02);
		rdc(8'h3A, 8'h00);
		{p0, p1} = 2'b11;
		acc(1, 8'h3B, 8'h40, 0);
		{p1, a0} = {1'b0, n_ack};
		wt(10);
		chk(n_ack - a0, 0);
		chk(pend, 2'b00);
		rdc(8'h3A, 8'h80);
		p0 = 0;
		wt(10);
		chk(core_model_inst.vec_log[a0 % 8], 12'h001);
		{p0, p1, rst_n} = 3'b110;
		wt(2);
		rst_n = 1;
		rdc(8'h3A, 8'h00);
		rdc(8'h3B, 8'h00);
		// A write made while the clock enable is low must not land.
		ce = 0;
		acc(1, 8'h3B, 8'hFF, 0);
		ce = 1;
		rdc(8'h3B, 8'h00);
		end_sim;
	end
	initial begin
		#100000;
		err_count++;
		end_sim;
	end
endmodule
bind ext_irq_ctrl ext_irq_ctrl_chk ext_irq_ctrl_chk_inst (.core_clk_in, .reset_n_in, .ce_in,
	.io_data_space_in, .io_wr_in, .io_rd_in, .io_addr_in, .io_wdata_in, .io_rdata_out,
	.global_irq_enable_in, .irq_req_out, .irq_line_out, .vector_table_select_out,
	.irq_vector_out, .pending_out);
